/* hw/hzd_element.sv */
// Zero-sequence current ratio differential element for the high-voltage winding.
// Assumes current samples arrive on ref_clk with a one-cycle valid strobe, in signed 0.1 A units.
`timescale 1ns/1ps
`default_nettype none
`include "hzd_regs.svh"
module hzd_element #(
    parameter int TICK_CYCLES = `HZD_TICK_CYCLES
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // Current samples.
    input wire logic sample_valid,
    input wire logic signed [15:0] phase_a_cur,
    input wire logic signed [15:0] phase_b_cur,
    input wire logic signed [15:0] phase_c_cur,
    input wire logic signed [15:0] neutral_cur,
    // Settings.
    input wire logic element_on_setting,
    input wire logic [6:0] terminal_tap,
    input wire logic [6:0] neutral_tap,
    input wire logic [7:0] min_operate_pct,
    input wire logic [6:0] slope1_pct,
    input wire logic [6:0] slope2_pct,
    input wire logic [9:0] break_pct,
    input wire hzd_pkg::hzd_ms_type operate_time_steps,
    input wire logic saturation_countermeasure_on,
    input wire logic overcurrent_block_on_setting,
    input wire logic [9:0] overcurrent_block_level,
    // Status.
    output logic in_region,
    output logic overcurrent_block,
    output logic external_fault,
    output logic detect
);
    import hzd_pkg::*;

    // A divider shorter than two clocks would leave the tick stuck high.
    if (TICK_CYCLES < 2) begin : g_bad_tick
        $error("TICK_CYCLES must be at least 2");
    end

    // ****************************************************************
    // Processing tick
    // ****************************************************************
    logic [31:0] div_r;
    logic tick;

    // One millisecond enable; every timer counts these.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= '0;
        end else if (div_r == 32'(TICK_CYCLES - 1)) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 32'h00000001;
        end
    end
    assign tick = (div_r == 32'(TICK_CYCLES - 1));

    // ****************************************************************
    // Differential and restraint quantities
    // ****************************************************************
    logic signed [17:0] sum3;
    logic signed [25:0] term_scaled;
    logic signed [25:0] neut_scaled;
    logic signed [26:0] diff_s;
    logic [47:0] id_mag;
    logic [47:0] ir_mag;
    logic [47:0] tap_prod;
    logic [47:0] lhs;
    logic [47:0] brk;
    logic [47:0] r100;
    logic [47:0] slope_thr;
    logic region_now;
    logic [15:0] max_phase;
    logic [9:0] oc_level;
    logic oc_now;

    function automatic logic [15:0] mag16(input logic signed [15:0] v);
        mag16 = v[15] ? 16'(-v) : 16'(v);
    endfunction

    // Both sides are brought to a common base, tap_t * tap_n, by cross-multiplying;
    // this avoids a divider at the cost of wider products.
    always_comb begin
        sum3 = 18'(phase_a_cur) + 18'(phase_b_cur) + 18'(phase_c_cur);
        term_scaled = 26'(sum3 * $signed({1'b0, neutral_tap}));
        neut_scaled = 26'(neutral_cur * $signed({1'b0, terminal_tap}));
        diff_s = 27'(term_scaled) - 27'(neut_scaled);
        id_mag = diff_s[26] ? 48'(-diff_s) : 48'(diff_s);
        ir_mag = 48'(term_scaled[25] ? -term_scaled : term_scaled);
        if (48'(neut_scaled[25] ? -neut_scaled : neut_scaled) > ir_mag) begin
            ir_mag = 48'(neut_scaled[25] ? -neut_scaled : neut_scaled);
        end
        tap_prod = 48'(terminal_tap) * 48'(neutral_tap);
        lhs = id_mag * 48'h000000002710;
        brk = 48'(break_pct) * tap_prod;
        r100 = ir_mag * 48'h000000000064;
        if (r100 <= brk) begin
            slope_thr = 48'(slope1_pct) * r100;
        end else begin
            slope_thr = 48'(slope1_pct) * brk + 48'(slope2_pct) * (r100 - brk);
        end
        region_now = (lhs > 48'(min_operate_pct) * tap_prod * 48'h000000000064) && (lhs > slope_thr);
    end

    // Overcurrent level clamped into its settable span.
    always_comb begin
        oc_level = overcurrent_block_level;
        if (oc_level < `HZD_OC_MIN) begin
            oc_level = `HZD_OC_MIN;
        end else if (oc_level > `HZD_OC_MAX) begin
            oc_level = `HZD_OC_MAX;
        end
        max_phase = mag16(phase_a_cur);
        if (mag16(phase_b_cur) > max_phase) begin
            max_phase = mag16(phase_b_cur);
        end
        if (mag16(phase_c_cur) > max_phase) begin
            max_phase = mag16(phase_c_cur);
        end
        if (mag16(neutral_cur) > max_phase) begin
            max_phase = mag16(neutral_cur);
        end
        oc_now = overcurrent_block_on_setting && (max_phase > 16'(oc_level));
    end

    // Quantities are judged once per sample and then held, except that turning the block setting off clears the block at once.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_region <= 1'b0;
            overcurrent_block <= 1'b0;
        end else if (sample_valid) begin
            in_region <= region_now;
            overcurrent_block <= oc_now;
        end else if (!overcurrent_block_on_setting) begin
            overcurrent_block <= 1'b0;
        end
    end

    // External fault: restraint past the break point while outside the region. Seen at
    // inception, before the CT saturates and starts to fake a differential.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            external_fault <= 1'b0;
        end else if (sample_valid) begin
            if (r100 > brk && !region_now) begin
                external_fault <= 1'b1;
            end else if (r100 <= brk) begin
                external_fault <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Timers and detection sequence
    // ****************************************************************
    hzd_tmr_if op_tmr ();
    hzd_tmr_if rst_tmr ();
    hzd_state_type state_r;
    logic trip_ok;

    assign trip_ok = element_on_setting && in_region && !overcurrent_block;
    assign op_tmr.tick = tick;
    assign rst_tmr.tick = tick;
    assign op_tmr.run = trip_ok && (state_r == HZD_CONFIRM);
    assign op_tmr.limit = 20'(operate_time_steps * `HZD_MS_PER_TIME_STEP)
        + ((saturation_countermeasure_on && external_fault) ? 20'(`HZD_SAT_EXTRA_MS) : 20'h00000);
    assign rst_tmr.run = (state_r == HZD_HOLD) && !trip_ok;
    assign rst_tmr.limit = 20'(`HZD_RESET_MS);

    hzd_timer u_op_timer (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .tmr(op_tmr.timer)
    );

    hzd_timer u_rst_timer (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .tmr(rst_tmr.timer)
    );

    // Detection sequence; disabling the element drops everything at once.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= HZD_IDLE;
        end else if (!element_on_setting) begin
            state_r <= HZD_IDLE;
        end else begin
            unique case (state_r)
                HZD_IDLE: begin
                    if (trip_ok) begin
                        state_r <= HZD_CONFIRM;
                    end
                end
                HZD_CONFIRM: begin
                    if (!trip_ok) begin
                        state_r <= HZD_IDLE;
                    end else if (op_tmr.done) begin
                        state_r <= HZD_ACTIVE;
                    end
                end
                HZD_ACTIVE: begin
                    if (!trip_ok) begin
                        state_r <= HZD_HOLD;
                    end
                end
                HZD_HOLD: begin
                    if (trip_ok) begin
                        state_r <= HZD_ACTIVE;
                    end else if (rst_tmr.done) begin
                        state_r <= HZD_IDLE;
                    end
                end
                default: begin
                    state_r <= HZD_IDLE;
                end
            endcase
        end
    end

    // Output from a flop so the relay contact sees a clean level.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            detect <= 1'b0;
        end else begin
            detect <= element_on_setting && (state_r == HZD_ACTIVE || state_r == HZD_HOLD);
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_confirm_done;
        state_r == HZD_CONFIRM && trip_ok && op_tmr.done;
    endsequence

    a_enable_gates_out: assert property (!element_on_setting |=> !detect)
        else $error("detect active with element off");
    a_operate_after_delay: assert property (s_confirm_done ##1 element_on_setting |=> detect)
        else $error("detect did not follow operate delay");
    a_rise_needs_timer: assert property ($rose(state_r == HZD_ACTIVE) && $past(state_r) == HZD_CONFIRM
        |-> $past(op_tmr.done) && $past(trip_ok))
        else $error("operate without expired timer");
    // The enable is taken one cycle back, so a drop to idle by disabling is not mistaken for expiry.
    a_hold_200ms: assert property ($fell(state_r == HZD_HOLD) && state_r == HZD_IDLE
        && $past(element_on_setting) |-> $past(rst_tmr.count) >= 20'(`HZD_RESET_MS))
        else $error("reset hold ended early");
    a_block_inhibits: assert property (overcurrent_block |-> !op_tmr.run ##1 (op_tmr.count == 20'h00000))
        else $error("operate timer ran while blocked");
    a_block_off_clear: assert property (!overcurrent_block_on_setting ##1 !overcurrent_block_on_setting
        |-> !overcurrent_block)
        else $error("block active with setting off");
    a_sat_extends: assert property (saturation_countermeasure_on && external_fault |->
        op_tmr.limit == 20'(operate_time_steps * `HZD_MS_PER_TIME_STEP) + 20'(`HZD_SAT_EXTRA_MS))
        else $error("confirmation not lengthened");
    a_sat_off_plain: assert property (!saturation_countermeasure_on |->
        op_tmr.limit == 20'(operate_time_steps * `HZD_MS_PER_TIME_STEP))
        else $error("confirmation lengthened with countermeasure off");
    // Currents at or below the lowest settable level can never block, whatever level is set.
    a_oc_floor_clear: assert property (sample_valid && max_phase <= 16'(`HZD_OC_MIN)
        |=> !overcurrent_block)
        else $error("block raised below the lowest settable level");
    a_region_min_op: assert property (sample_valid && region_now |=> in_region)
        else $error("region flag not captured");

endmodule : hzd_element
`default_nettype wire

/* hw/hzd_pkg.sv */
// Types shared by the zero-sequence ratio differential element.
// Assumes nothing of its surroundings.
`default_nettype none
package hzd_pkg;

    // Detection sequence, one-hot.
    typedef enum logic [3:0] {
        HZD_IDLE = 4'h1,
        HZD_CONFIRM = 4'h2,
        HZD_ACTIVE = 4'h4,
        HZD_HOLD = 4'h8
    } hzd_state_type;

    typedef logic [19:0] hzd_ms_type;

endpackage : hzd_pkg
`default_nettype wire

/* hw/hzd_regs.svh */
// Constants of the zero-sequence ratio differential element: timing counts and setting limits.
// Assumes a 200 MHz ref_clk and settings that arrive as plain ports.
//
// Overview of operation
// - Sum the three terminal currents and combine with neutral current into a differential.
// - Scale terminal and neutral sides by their matching taps before differential and restraint.
// - With overcurrent blocking on, inhibit operation while a current exceeds the threshold.
// - An external fault seen before saturation lengthens the confirmation time to operate.
// - With the saturation countermeasure off, the normal confirmation time alone applies.
// - Detection asserts only after the operate delay, timed while in region and unblocked.
// - After the trip condition clears, detection holds for 200 ms before dropping.
// - The output is active only while the element enable setting is on.
// - The overcurrent-block threshold spans 5.0 A to 50.0 A in 0.1 A steps.
`ifndef HZD_REGS_SVH
`define HZD_REGS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define HZD_CLK_PERIOD_NS 5
`define HZD_TICK_NS 1000000
`define HZD_TICK_CYCLES (`HZD_TICK_NS / `HZD_CLK_PERIOD_NS)
`define HZD_RESET_MS 200
`define HZD_SAT_EXTRA_MS 20
`define HZD_MS_PER_TIME_STEP 100

// ****************************************************************
// Setting limits, currents in 0.1 A steps
// ****************************************************************
`define HZD_OC_MIN 10'h032
`define HZD_OC_MAX 10'h1F4

`endif

/* hw/hzd_timer.sv */
// Millisecond timer that counts processing ticks while its run level stands.
// Assumes tick is a one-cycle enable on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module hzd_timer (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // Timer side.
    hzd_tmr_if.timer tmr
);
    import hzd_pkg::*;

    hzd_ms_type cnt_r;

    // Any drop of run restarts from zero, so a brief condition never accumulates.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else if (!tmr.run) begin
            cnt_r <= '0;
        end else if (tmr.tick && !tmr.done) begin
            cnt_r <= cnt_r + 20'h00001;
        end
    end

    assign tmr.done = tmr.run && (cnt_r >= tmr.limit);
    assign tmr.count = cnt_r;

    a_timer_restart: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !tmr.run |=> cnt_r == '0) else $error("timer not cleared after run dropped");

endmodule : hzd_timer
`default_nettype wire

/* hw/hzd_tmr_if.sv */
// Interface between the element and one of its millisecond timers.
// Assumes both ends run on ref_clk.
`timescale 1ns/1ps
`default_nettype none
interface hzd_tmr_if;
    import hzd_pkg::*;
    logic run;
    logic tick;
    hzd_ms_type limit;
    logic done;
    hzd_ms_type count;
    modport owner (output run, output tick, output limit, input done, input count);
    modport timer (input run, input tick, input limit, output done, output count);
endinterface : hzd_tmr_if
`default_nettype wire

/* sim/hzd_ct_src.sv */
// Model of the CT sampling front end that feeds the element.
// Assumes the bench raises req for one ref_clk cycle per sample.
`timescale 1ns/1ps
`default_nettype none
module hzd_ct_src (
    // Clock.
    input wire logic ref_clk,
    // Request from the bench.
    input wire logic req,
    input wire logic signed [15:0] cur_in [4],
    // Sample to the element.
    output logic sample_valid,
    output logic signed [15:0] cur_out [4]
);
    // Lines start quiet so no input of the element is unknown at time zero.
    initial begin
        sample_valid = 1'b0;
        cur_out = '{default: 16'sh0000};
    end
    // Outside a sample the lines carry the inverse, so stale data never passes for a valid one.
    always @(posedge ref_clk) begin
        sample_valid <= req;
        for (int i = 0; i < 4; i++) begin
            cur_out[i] <= req ? cur_in[i] : ~cur_in[i];
        end
    end
endmodule : hzd_ct_src
`default_nettype wire

/* sim/zero_seq_ratio_diff_element_test.sv */
// Self-checking bench of the element against an integer model.
// Assumes the element is built with a short tick of four clocks.
`timescale 1ns/1ps
`default_nettype none
`include "hzd_regs.svh"
module zero_seq_ratio_diff_element_test;
    import hzd_pkg::*;
    localparam int TC = 4;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic req = 1'b0;
    logic signed [15:0] cur [4] = '{default: 16'sh0000};
    logic signed [15:0] cur_o [4];
    logic sample_valid, in_region, overcurrent_block, external_fault, detect;
    logic en = 1'b1, sat = 1'b0, oc_on = 1'b0;
    logic [6:0] tt = 7'h32, tn = 7'h32, k1 = 7'h1E, k2 = 7'h3C;
    logic [7:0] mo = 8'h14;
    logic [9:0] brk = 10'h0C8, lvl = 10'h064;
    hzd_ms_type steps = 20'h00000;
    int fails = 0, n_compared = 0, e_st = 0, e_unk = 0;
    logic [31:0] seed = 32'h620C5853;

    // Clock of 200 MHz.
    always #2.5 ref_clk = ~ref_clk;

    hzd_ct_src i_src (.ref_clk(ref_clk), .req(req), .cur_in(cur), .sample_valid(sample_valid),
        .cur_out(cur_o));
    hzd_element #(.TICK_CYCLES(TC)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .sample_valid(sample_valid),
        .phase_a_cur(cur_o[0]), .phase_b_cur(cur_o[1]), .phase_c_cur(cur_o[2]), .neutral_cur(cur_o[3]),
        .element_on_setting(en), .terminal_tap(tt), .neutral_tap(tn), .min_operate_pct(mo),
        .slope1_pct(k1), .slope2_pct(k2), .break_pct(brk), .operate_time_steps(steps),
        .saturation_countermeasure_on(sat), .overcurrent_block_on_setting(oc_on),
        .overcurrent_block_level(lvl), .in_region(in_region), .overcurrent_block(overcurrent_block),
        .external_fault(external_fault), .detect(detect));

    // ****************************************
    // Helpers
    // ****************************************
    function automatic int rnd(int m);
        seed = seed[0] ? ((seed >> 1) ^ 32'hA3000000) : (seed >> 1);
        return int'(seed % m);
    endfunction : rnd

    function automatic longint ab(longint x);
        return x < 0 ? -x : x;
    endfunction : ab

    // Rounding inside the element is its own, so points within 5 percent of an edge are not judged.
    function automatic bit near(longint l, longint r, longint p);
        return (l > r ? l - r : r - l) * 20 <= r + 100 * p;
    endfunction : near

    task automatic chk(string nm, logic exp, logic got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %b seen %b", nm, exp, got);
        end
    endtask : chk

    task automatic give_verdict();
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict

    // Sends one sample, then checks the three status outputs against the model.
    task automatic send(input int v [4]);
        longint s, d, r, p, b, l2, r2, mx;
        int tl, nl, lv;
        bit rg, unk, ocx;
        @(posedge ref_clk);
        req <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            cur[i] <= 16'(v[i]);
        end
        @(posedge ref_clk);
        req <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        tl = int'(tt);
        nl = int'(tn);
        s = v[0] + v[1] + v[2];
        p = tl * nl;
        d = ab(s * nl - v[3] * tl);
        r = ab(s * nl) > ab(v[3] * tl) ? ab(s * nl) : ab(v[3] * tl);
        b = int'(brk) * p;
        l2 = (100 * r <= b) ? 100 * d : 10000 * d;
        r2 = (100 * r <= b) ? int'(k1) * r : int'(k1) * b + int'(k2) * (100 * r - b);
        rg = (100 * d > int'(mo) * p) && (l2 > r2);
        unk = near(100 * d, int'(mo) * p, p) || near(l2, r2, p) || near(100 * r, b, p);
        mx = 0;
        for (int i = 0; i < 4; i++) begin
            mx = ab(v[i]) > mx ? ab(v[i]) : mx;
        end
        lv = lvl < `HZD_OC_MIN ? `HZD_OC_MIN : (lvl > `HZD_OC_MAX ? `HZD_OC_MAX : lvl);
        ocx = oc_on && (mx > lv);
        if (unk) begin
            e_unk = 1;
        end else if (100 * r <= b) begin
            e_st = 0;
            e_unk = 0;
        end else if (!rg) begin
            e_st = 1;
            e_unk = 0;
        end
        if (!unk) chk("in_region", rg, in_region);
        chk("overcurrent_block", ocx, overcurrent_block);
        if (e_unk == 0) chk("external_fault", 1'(e_st), external_fault);
    endtask : send

    // Waits for detect to reach a level, or with fixed set, holds for the whole span first.
    task automatic det(logic exp, int maxc, bit fixed);
        for (int i = 0; i < maxc && (fixed || detect !== exp); i++) begin
            @(posedge ref_clk);
            #1;
        end
        chk("detect", exp, detect);
    endtask : det

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        send('{0, 0, 0, 0});
        send('{60, 0, 0, 0});
        det(1'b1, 30, 1'b0);
        send('{0, 0, 0, 0});
        det(1'b1, 700, 1'b1);
        det(1'b0, 200, 1'b0);
        @(posedge ref_clk) oc_on <= 1'b1;
        send('{300, 0, 0, 0});
        det(1'b0, 60, 1'b1);
        @(posedge ref_clk) oc_on <= 1'b0;
        send('{300, 0, 0, 0});
        det(1'b1, 30, 1'b0);
        @(posedge ref_clk) en <= 1'b0;
        det(1'b0, 3, 1'b0);
        send('{300, 0, 0, 0});
        det(1'b0, 60, 1'b1);
        send('{0, 0, 0, 0});
        @(posedge ref_clk) en <= 1'b1;
        @(posedge ref_clk) sat <= 1'b1;
        send('{300, 0, 0, 300});
        send('{300, 0, 0, 0});
        det(1'b0, 40, 1'b1);
        det(1'b1, 100, 1'b0);
        @(posedge ref_clk) en <= 1'b0;
        send('{0, 0, 0, 0});
        @(posedge ref_clk) en <= 1'b1;
        @(posedge ref_clk) sat <= 1'b0;
        send('{300, 0, 0, 300});
        send('{300, 0, 0, 0});
        det(1'b1, 30, 1'b0);
        // One time step is 100 ticks; the fault flag stands but the countermeasure is off.
        @(posedge ref_clk) steps <= 20'h00001;
        @(posedge ref_clk) en <= 1'b0;
        @(posedge ref_clk) en <= 1'b1;
        det(1'b0, 380, 1'b1);
        det(1'b1, 40, 1'b0);
        // A long operate time keeps detect low while random points sweep the region.
        @(posedge ref_clk) steps <= 20'h003E8;
        @(posedge ref_clk) en <= 1'b0;
        @(posedge ref_clk) en <= 1'b1;
        for (int i = 0; i < 200; i++) begin
            @(posedge ref_clk);
            tt <= 7'(22 + rnd(104));
            tn <= 7'(22 + rnd(104));
            mo <= 8'(10 + rnd(191));
            k1 <= 7'(10 + rnd(91));
            k2 <= 7'(10 + rnd(91));
            brk <= 10'(100 + rnd(901));
            lvl <= 10'(rnd(1024));
            oc_on <= 1'(rnd(2));
            send('{rnd(401) - 200, rnd(401) - 200, rnd(401) - 200, rnd(801) - 400});
            chk("detect", 1'b0, detect);
        end
        give_verdict();
    end

    // The scenarios need some 3000 cycles; sixteen times that means a hang.
    initial begin
        #240000;
        fails++;
        give_verdict();
    end
endmodule : zero_seq_ratio_diff_element_test
`default_nettype wire
